// ===== include/stats_defines.vh
// Behaviour
// R1 - segments are cycled by the multiplexer only when two or more are enabled
// R2 - frame statistics are gathered only while the selected segment is monitored
// R3 - each segment has an activity flag, set only while it is being measured
// R4 - one independent counter per observed frame category
// R5 - counters are read as absolute running totals
// R6 - counters wrap to zero on overflow, never saturate
// R7 - every counter clears together when the multiplexer switches segment
// R8 - a clear command resets all counters together, apart from any switch
// R9 - the valid-frame counter increments once per received frame
// R10 - check sum is recomputed per frame; mismatch increments the check-error counter
// R11 - a token pass not answered at once by a token return is a sequence error
// R12 - separate counters for idle, token, probe, time, compel, data and connection frames
// R13 - frames of no known category go to the unrecognized counter
// R14 - jitter is timed over 16 edges from preamble to end of start delimiter
// R15 - weakest device amplitude is tracked together with its bus address
// R16 - the number of distinct active devices is reported, each card counting once
// R17 - bus load is kept for upkeep, periodic, aperiodic and idle frames apart
// R18 - the unused bus time is counted as well
// R19 - frame-error figure equals check errors plus sequence errors
// R20 - category comes from the control byte after start; one category count per frame
// R21 - a clear in the same cycle as a count leaves the counter at zero
`ifndef STATS_DEFINES_VH
`define STATS_DEFINES_VH

`define CLK_MHZ        250
`define SEG_DWELL_US   1000
`define SEG_W          4
`define SEG_NUM        16
`define CNT_W          32
`define SEL_W          5
`define LEVEL_W        12
`define LEVEL_NONE     12'hfff
`define ADDR_W         8
`define DEV_W          9
`define JIT_W          16
`define EDGE_SPAN      5'h10

// counter indices
`define CNT_VALID      5'h00
`define CNT_CRC        5'h01
`define CNT_SEQ        5'h02
`define CNT_IDLE       5'h03
`define CNT_UNREC      5'h04
`define CNT_PT         5'h05
`define CNT_RT         5'h06
`define CNT_PN         5'h07
`define CNT_TD         5'h08
`define CNT_CD         5'h09
`define CNT_DT_LO      5'h0a
`define CNT_DT_HI      5'h0b
`define CNT_DC         5'h0c
`define CNT_EC         5'h0d
`define LD_UPKEEP      5'h0e
`define LD_PERIODIC    5'h0f
`define LD_APERIODIC   5'h10
`define LD_IDLE        5'h11
`define LD_UNUSED      5'h12
`define CNT_NUM        19
`define LD_FIRST       14
`define LD_LAST        17

// frame control codes
`define FC_IDLE        8'h08
`define FC_PT          8'h30
`define FC_RT          8'h31
`define FC_PN          8'h32
`define FC_TD          8'h33
`define FC_CD          8'h40
`define FC_DT1         8'h50
`define FC_DT2         8'h51
`define FC_DT3         8'h53
`define FC_DT5         8'h55
`define FC_DC          8'h60
`define FC_EC          8'h61

// check sum
`define CRC_INIT       16'hffff
`define CRC_POLY       16'h1021
`define CRC_RESIDUE    16'h1d0f

`endif

// ===== logic/frame_crc.v
`timescale 1ns/1ns
`include "stats_defines.vh"
module frame_crc
(
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// byte stream
	input  wire        start_i,
	input  wire        byte_valid_i,
	input  wire [7:0]  byte_i,
	// result
	output wire        ok_o
);
	reg  [15:0] crc_q;
	reg  [15:0] crc_d;
	integer     k;

	// running over data and carried check sum leaves a fixed residue
	always @*
	begin
		crc_d = crc_q;
		for (k = 7; k >= 0; k = k - 1)
			crc_d = {crc_d[14:0], 1'b0} ^ ((crc_d[15] ^ byte_i[k]) ? `CRC_POLY : 16'h0000);
	end

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			crc_q <= `CRC_INIT;
		else if (start_i)
			crc_q <= `CRC_INIT;
		else if (byte_valid_i)
			crc_q <= crc_d;
	end

	assign ok_o = (crc_q == `CRC_RESIDUE);
endmodule

// ===== logic/counter_bank.v
`timescale 1ns/1ns
`include "stats_defines.vh"
module counter_bank
(
	// clock and reset
	input  wire                clk_i,
	input  wire                rst_i,
	// update
	input  wire                clr_i,
	input  wire [`CNT_NUM-1:0] inc_i,
	input  wire [`CNT_W-1:0]   len_i,
	// read
	input  wire                rd_req_i,
	input  wire [`SEL_W-1:0]   rd_sel_i,
	output wire [`CNT_W-1:0]   rd_data_o,
	output wire                rd_valid_o
);
	reg  [`CNT_W-1:0]           cnt_q [0:`CNT_NUM-1];
	reg  [`CNT_W-1:0]           rd_data_q;
	reg                         rd_valid_q;
	wire [`CNT_NUM*`CNT_W-1:0]  step;
	integer                     i;

	genvar g;
	generate
		for (g = 0; g < `CNT_NUM; g = g + 1)
		begin : g_step
			assign step[g*`CNT_W +: `CNT_W] = (g >= `LD_FIRST && g <= `LD_LAST) ? len_i : 32'h00000001;
		end
	endgenerate

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (i = 0; i < `CNT_NUM; i = i + 1)
				cnt_q[i] <= 32'h00000000;
		end
		else
		begin
			for (i = 0; i < `CNT_NUM; i = i + 1)
				// R21 clear beats count
				// R8 common clear
				if (clr_i)
					cnt_q[i] <= 32'h00000000;
				// R6 plain wrap
				else if (inc_i[i])
					cnt_q[i] <= cnt_q[i] + step[i*`CNT_W +: `CNT_W];
		end
	end

	// R5 absolute totals
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rd_data_q  <= 32'h00000000;
			rd_valid_q <= 1'b0;
		end
		else
		begin
			rd_valid_q <= rd_req_i;
			if (rd_req_i)
				rd_data_q <= (rd_sel_i < `CNT_NUM) ? cnt_q[rd_sel_i] : 32'h00000000;
		end
	end

	assign rd_data_o  = rd_data_q;
	assign rd_valid_o = rd_valid_q;
endmodule

// ===== logic/segment_frame_statistics.v
`timescale 1ns/1ns
`include "stats_defines.vh"
module segment_frame_statistics
#(
	parameter [31:0] DWELL_CYCLES = `SEG_DWELL_US * `CLK_MHZ
)
(
	// clock and reset
	input  wire                 clk_i,
	input  wire                 rst_i,
	// configuration
	input  wire [`SEG_NUM-1:0]  seg_enable_i,
	// frame receiver of the selected segment
	input  wire                 frm_start_i,
	input  wire                 frm_byte_valid_i,
	input  wire [7:0]           frm_byte_i,
	input  wire                 frm_end_i,
	input  wire                 edge_i,
	// amplitude measurement
	input  wire                 amp_valid_i,
	input  wire [`LEVEL_W-1:0]  amp_level_i,
	input  wire [`ADDR_W-1:0]   amp_addr_i,
	// diagnostic bus
	input  wire                 clear_i,
	input  wire                 rd_req_i,
	input  wire [`SEL_W-1:0]    rd_sel_i,
	output wire [`CNT_W-1:0]    rd_data_o,
	output wire                 rd_valid_o,
	// segment selection
	output wire [`SEG_W-1:0]    seg_sel_o,
	output wire [`SEG_NUM-1:0]  seg_active_o,
	// figures
	output wire [`CNT_W-1:0]    frame_error_o,
	output wire [`LEVEL_W-1:0]  min_level_o,
	output wire [`ADDR_W-1:0]   min_level_addr_o,
	output wire [`DEV_W-1:0]    device_count_o,
	output wire [`JIT_W-1:0]    jitter_o
);
	localparam [1:0] ST_OFF  = 2'b01;
	localparam [1:0] ST_MEAS = 2'b10;
	localparam [2:0] F_WAIT  = 3'b001;
	localparam [2:0] F_FC    = 3'b010;
	localparam [2:0] F_BODY  = 3'b100;

	// R20 control byte to category
	function [`SEL_W-1:0] fc_category;
		input [7:0] fc;
		begin
			case (fc)
				`FC_IDLE: fc_category = `CNT_IDLE;
				`FC_PT:   fc_category = `CNT_PT;
				`FC_RT:   fc_category = `CNT_RT;
				`FC_PN:   fc_category = `CNT_PN;
				`FC_TD:   fc_category = `CNT_TD;
				`FC_CD:   fc_category = `CNT_CD;
				`FC_DT1:  fc_category = `CNT_DT_LO;
				`FC_DT2:  fc_category = `CNT_DT_LO;
				`FC_DT3:  fc_category = `CNT_DT_HI;
				`FC_DT5:  fc_category = `CNT_DT_HI;
				`FC_DC:   fc_category = `CNT_DC;
				`FC_EC:   fc_category = `CNT_EC;
				// R13 unknown control byte
				default:  fc_category = `CNT_UNREC;
			endcase
		end
	endfunction

	// R17 category to load class
	function [`SEL_W-1:0] load_class;
		input [`SEL_W-1:0] cat;
		begin
			case (cat)
				`CNT_IDLE:                       load_class = `LD_IDLE;
				`CNT_PT, `CNT_RT, `CNT_PN, `CNT_TD: load_class = `LD_UPKEEP;
				`CNT_CD, `CNT_DT_LO:             load_class = `LD_PERIODIC;
				default:                         load_class = `LD_APERIODIC;
			endcase
		end
	endfunction

	// first enabled segment after cur, wrapping; cur itself if it is alone
	function [`SEG_W-1:0] next_seg;
		input [`SEG_W-1:0]   cur;
		input [`SEG_NUM-1:0] m;
		integer              k;
		reg   [`SEG_W:0]     idx;
		begin
			next_seg = cur;
			for (k = `SEG_NUM - 1; k >= 1; k = k - 1)
			begin
				idx = {1'b0, cur} + k[`SEG_W:0];
				if (m[idx[`SEG_W-1:0]])
					next_seg = idx[`SEG_W-1:0];
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// segment multiplexer
	// ----------------------------------------------------------------
	reg  [1:0]           st_q, st_d;
	reg  [`SEG_W-1:0]    sel_q, sel_d;
	reg  [31:0]          dwell_q;
	reg  [`SEG_NUM-1:0]  active_q;
	reg                  switch_d;
	wire                 any_en = |seg_enable_i;
	wire                 multi  = |(seg_enable_i & (seg_enable_i - 16'h0001));
	wire                 dwell_done = (dwell_q >= DWELL_CYCLES - 32'h00000001);

	always @*
	begin
		st_d     = st_q;
		sel_d    = sel_q;
		switch_d = 1'b0;
		case (st_q)
			ST_OFF:
				if (any_en)
				begin
					st_d     = ST_MEAS;
					sel_d    = seg_enable_i[sel_q] ? sel_q : next_seg(sel_q, seg_enable_i);
					switch_d = 1'b1;
				end
			ST_MEAS:
				if (!any_en)
				begin
					st_d     = ST_OFF;
					switch_d = 1'b1;
				end
				else if (!seg_enable_i[sel_q])
				begin
					sel_d    = next_seg(sel_q, seg_enable_i);
					switch_d = 1'b1;
				end
				// R1 cycle only with two or more
				else if (multi && dwell_done)
				begin
					sel_d    = next_seg(sel_q, seg_enable_i);
					switch_d = 1'b1;
				end
			default:
			begin
				st_d     = ST_OFF;
				switch_d = 1'b1;
			end
		endcase
	end

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_q     <= ST_OFF;
			sel_q    <= 4'h0;
			dwell_q  <= 32'h00000000;
			active_q <= 16'h0000;
		end
		else
		begin
			st_q    <= st_d;
			sel_q   <= sel_d;
			dwell_q <= switch_d ? 32'h00000000 : dwell_q + 32'h00000001;
			// R3 activity per segment
			active_q <= (st_d == ST_MEAS) ? (16'h0001 << sel_d) : 16'h0000;
		end
	end

	// R2 observe only the selected segment while settled on it
	wire mon = (st_q == ST_MEAS) && !switch_d;
	// R7 switch clears, R8 command clears
	wire clr = switch_d | clear_i;

	// ----------------------------------------------------------------
	// frame tracking
	// ----------------------------------------------------------------
	reg  [2:0]           f_q;
	reg  [`SEL_W-1:0]    cat_q;
	reg  [`CNT_W-1:0]    len_q;
	reg                  pend_q;
	reg  [`CNT_W-1:0]    ferr_q;
	reg  [`CNT_NUM-1:0]  inc;
	wire                 crc_ok;
	wire                 done = mon && frm_end_i && (f_q != F_WAIT);
	wire                 crc_bad = !crc_ok;
	wire                 seq_bad = pend_q && (cat_q != `CNT_RT);

	frame_crc u_crc
	(
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.start_i      (frm_start_i),
		.byte_valid_i (frm_byte_valid_i && f_q != F_WAIT),
		.byte_i       (frm_byte_i),
		.ok_o         (crc_ok)
	);

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			f_q    <= F_WAIT;
			cat_q  <= `CNT_UNREC;
			len_q  <= 32'h00000000;
			pend_q <= 1'b0;
			ferr_q <= 32'h00000000;
		end
		else
		begin
			len_q <= len_q + 32'h00000001;
			if (clr)
			begin
				pend_q <= 1'b0;
				ferr_q <= 32'h00000000;
			end
			else if (done)
			begin
				// R11 token pass awaits return
				pend_q <= (cat_q == `CNT_PT);
				// R19 check plus sequence errors
				ferr_q <= ferr_q + {31'h00000000, crc_bad} + {31'h00000000, seq_bad};
			end
			case (f_q)
				F_WAIT:
					if (mon && frm_start_i)
					begin
						f_q   <= F_FC;
						cat_q <= `CNT_UNREC;
						len_q <= 32'h00000001;
					end
				F_FC:
					if (!mon || frm_end_i)
						f_q <= F_WAIT;
					// R20 decide from control byte
					else if (frm_byte_valid_i)
					begin
						cat_q <= fc_category(frm_byte_i);
						f_q   <= F_BODY;
					end
				F_BODY:
					if (!mon || frm_end_i)
						f_q <= F_WAIT;
				default:
					f_q <= F_WAIT;
			endcase
		end
	end

	// R4 one counter per category
	always @*
	begin
		inc = {`CNT_NUM{1'b0}};
		if (done)
		begin
			// R9 every frame
			inc[`CNT_VALID] = 1'b1;
			// R10 check sum mismatch
			inc[`CNT_CRC] = crc_bad;
			// R11 missing token return
			inc[`CNT_SEQ] = seq_bad;
			// R12 exactly one category
			inc[cat_q] = 1'b1;
			// R17 frame time by load class
			inc[load_class(cat_q)] = 1'b1;
		end
		// R18 idle bus time
		inc[`LD_UNUSED] = mon && (f_q == F_WAIT) && !frm_start_i;
	end

	counter_bank u_bank
	(
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.clr_i      (clr),
		.inc_i      (inc),
		.len_i      (len_q),
		.rd_req_i   (rd_req_i),
		.rd_sel_i   (rd_sel_i),
		.rd_data_o  (rd_data_o),
		.rd_valid_o (rd_valid_o)
	);

	// ----------------------------------------------------------------
	// jitter over the preamble
	// ----------------------------------------------------------------
	reg  [4:0]          ecnt_q;
	reg  [`JIT_W-1:0]   gap_q, gmin_q, gmax_q, jit_q;
	wire                first_gap = (ecnt_q == 5'h01);
	wire [`JIT_W-1:0]   gmin_n = (first_gap || gap_q < gmin_q) ? gap_q : gmin_q;
	wire [`JIT_W-1:0]   gmax_n = (first_gap || gap_q > gmax_q) ? gap_q : gmax_q;

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ecnt_q <= 5'h00;
			gap_q  <= 16'h0000;
			gmin_q <= 16'h0000;
			gmax_q <= 16'h0000;
			jit_q  <= 16'h0000;
		end
		else
		begin
			// saturate so a long pause is not misread as a short gap
			if (gap_q != 16'hffff)
				gap_q <= gap_q + 16'h0001;
			if (clr)
			begin
				ecnt_q <= 5'h00;
				jit_q  <= 16'h0000;
			end
			else if (f_q != F_WAIT || frm_start_i)
				ecnt_q <= 5'h00;
			// R14 sixteen edges up to the delimiter end
			else if (mon && edge_i && ecnt_q < `EDGE_SPAN)
			begin
				gap_q  <= 16'h0000;
				ecnt_q <= ecnt_q + 5'h01;
				if (ecnt_q != 5'h00)
				begin
					gmin_q <= gmin_n;
					gmax_q <= gmax_n;
					if (ecnt_q == `EDGE_SPAN - 5'h01)
						jit_q <= gmax_n - gmin_n;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// device amplitude and population
	// ----------------------------------------------------------------
	reg  [`LEVEL_W-1:0]    lmin_q;
	reg  [`ADDR_W-1:0]     laddr_q;
	reg  [(1<<`ADDR_W)-1:0] seen_q;
	reg  [`DEV_W-1:0]      ndev_q;

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			lmin_q  <= `LEVEL_NONE;
			laddr_q <= 8'h00;
			seen_q  <= {(1<<`ADDR_W){1'b0}};
			ndev_q  <= 9'h000;
		end
		else if (clr)
		begin
			lmin_q  <= `LEVEL_NONE;
			laddr_q <= 8'h00;
			seen_q  <= {(1<<`ADDR_W){1'b0}};
			ndev_q  <= 9'h000;
		end
		else if (mon && amp_valid_i)
		begin
			// R15 weakest level and its address
			if (amp_level_i < lmin_q)
			begin
				lmin_q  <= amp_level_i;
				laddr_q <= amp_addr_i;
			end
			// R16 each address counted once
			if (!seen_q[amp_addr_i])
			begin
				seen_q[amp_addr_i] <= 1'b1;
				ndev_q             <= ndev_q + 9'h001;
			end
		end
	end

	assign seg_sel_o        = sel_q;
	assign seg_active_o     = active_q;
	assign frame_error_o    = ferr_q;
	assign min_level_o      = lmin_q;
	assign min_level_addr_o = laddr_q;
	assign device_count_o   = ndev_q;
	assign jitter_o         = jit_q;
endmodule

// ===== verification/seg_stats_asserts.sv
`timescale 1ns/1ns
`include "stats_defines.vh"
module seg_stats_asserts
#(
	parameter [31:0] DWELL_CYCLES = 32'd50
)
(
	// clock and reset
	input wire                clk_i,
	input wire                rst_i,
	// inputs watched
	input wire [`SEG_NUM-1:0] seg_enable_i,
	input wire                frm_end_i,
	input wire                edge_i,
	input wire                amp_valid_i,
	input wire [`LEVEL_W-1:0] amp_level_i,
	input wire                clear_i,
	input wire                rd_req_i,
	// outputs watched
	input wire                rd_valid_o,
	input wire [`SEG_W-1:0]   seg_sel_o,
	input wire [`SEG_NUM-1:0] seg_active_o,
	input wire [`CNT_W-1:0]   frame_error_o,
	input wire [`LEVEL_W-1:0] min_level_o,
	input wire [`DEV_W-1:0]   device_count_o,
	input wire [`JIT_W-1:0]   jitter_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_RD_ANSWER: assert property (rd_req_i |=> rd_valid_o)
		else $error("read not answered");
	AST_RD_PULSE: assert property (!rd_req_i |=> !rd_valid_o)
		else $error("read valid without request");
	AST_CLEAR_ZERO: assert property (clear_i |=> frame_error_o == 0 && device_count_o == 0 && jitter_o == 0)
		else $error("clear left figures set");
	AST_SWITCH_ZERO: assert property (!$stable(seg_sel_o) |-> frame_error_o == 0 && device_count_o == 0)
		else $error("switch left figures set");
	AST_ONE_HOT: assert property (seg_active_o != 0 |-> seg_active_o == (32'h1 << seg_sel_o))
		else $error("activity flag not on selected segment");
	AST_SINGLE_STAYS: assert property ((seg_active_o != 0 && $countones(seg_enable_i) == 1
		&& $stable(seg_enable_i)) |=> $stable(seg_sel_o))
		else $error("single segment was switched");
	AST_ERR_HOLD: assert property (!frm_end_i |=> frame_error_o == $past(frame_error_o) || frame_error_o == 0)
		else $error("frame error moved without frame end");
	AST_MIN_TRACK: assert property ((amp_valid_i && seg_active_o != 0 && amp_level_i < min_level_o && !clear_i)
		|-> ##[1:2] (min_level_o == $past(amp_level_i, 1) || min_level_o == `LEVEL_NONE))
		else $error("weaker level not recorded");
	AST_JIT_HOLD: assert property ((!edge_i && !clear_i) |=> $stable(jitter_o) || jitter_o == 0)
		else $error("jitter moved without edge");

	cover property (rd_req_i ##1 rd_valid_o);
	cover property (clear_i);
	cover property (!$stable(seg_sel_o) && seg_active_o != 0);
endmodule

bind segment_frame_statistics seg_stats_asserts #(.DWELL_CYCLES(DWELL_CYCLES)) u_asserts (.clk_i, .rst_i,
	.seg_enable_i, .frm_end_i, .edge_i, .amp_valid_i, .amp_level_i, .clear_i, .rd_req_i, .rd_valid_o,
	.seg_sel_o, .seg_active_o, .frame_error_o, .min_level_o, .device_count_o, .jitter_o);

// ===== verification/seg_bus_model.sv
`timescale 1ns/1ns
module seg_bus_model
(
	// clock
	input  wire       clk_i,
	// frame receiver side
	output reg        start_o,
	output reg        byte_valid_o,
	output reg  [7:0] byte_o,
	output reg        end_o,
	output reg        edge_o
);
	initial
	begin
		start_o = 1'b0;
		byte_valid_o = 1'b0;
		byte_o = 8'h00;
		end_o = 1'b0;
		edge_o = 1'b0;
	end

	task send(input [7:0] fc, input bad);
		reg [15:0] c;
		reg [23:0] b;
		integer i;
		begin
			for (i = 0; i < 16; i = i + 1)
			begin
				@(posedge clk_i) edge_o <= 1'b1;
				@(posedge clk_i) edge_o <= 1'b0;
				if (i % 2)
					@(posedge clk_i);
			end
			c = 16'hffff;
			for (i = 7; i >= 0; i = i - 1)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ fc[i]) ? 16'h1021 : 16'h0000);
			b = {fc, ~c[15:8], ~c[7:0] ^ {7'h00, bad}};
			@(posedge clk_i) start_o <= 1'b1;
			for (i = 0; i < 3; i = i + 1)
			begin
				@(posedge clk_i) start_o <= 1'b0;
				byte_valid_o <= 1'b1;
				byte_o <= b[23-8*i -: 8];
			end
			// released line never holds its last byte
			@(posedge clk_i) byte_valid_o <= 1'b0;
			byte_o <= ~byte_o;
			end_o <= 1'b1;
			@(posedge clk_i) end_o <= 1'b0;
		end
	endtask
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ns
`include "stats_defines.vh"
module tb;
	localparam [111:0] TBL = 112'h08_30_31_32_33_40_50_51_53_55_60_61_77_30;
	reg                 clk_i, rst_i, clear_i, rd_req_i, amp_valid_i, bad;
	reg [`SEG_NUM-1:0]  seg_enable_i;
	reg [`SEL_W-1:0]    rd_sel_i;
	reg [`LEVEL_W-1:0]  amp_level_i;
	reg [`ADDR_W-1:0]   amp_addr_i;
	reg [7:0]           fc;
	reg [255:0]         seen;
	wire                frm_start_i, frm_byte_valid_i, frm_end_i, edge_i, rd_valid_o;
	wire [7:0]          frm_byte_i;
	wire [`CNT_W-1:0]   rd_data_o, frame_error_o;
	wire [`SEG_W-1:0]   seg_sel_o;
	wire [`SEG_NUM-1:0] seg_active_o;
	wire [`LEVEL_W-1:0] min_level_o;
	wire [`ADDR_W-1:0]  min_level_addr_o;
	wire [`DEV_W-1:0]   device_count_o;
	wire [`JIT_W-1:0]   jitter_o;
	integer             num_errors, n_checks, seed, i, j, k, n_dev, prev_pt, exp_min, exp_addr;
	integer             cnt [0:18];

	// short dwell keeps the segment rotation test brief
	segment_frame_statistics #(.DWELL_CYCLES(32'd50)) u_dut (.clk_i, .rst_i, .seg_enable_i, .frm_start_i,
		.frm_byte_valid_i, .frm_byte_i, .frm_end_i, .edge_i, .amp_valid_i, .amp_level_i, .amp_addr_i,
		.clear_i, .rd_req_i, .rd_sel_i, .rd_data_o, .rd_valid_o, .seg_sel_o, .seg_active_o,
		.frame_error_o, .min_level_o, .min_level_addr_o, .device_count_o, .jitter_o);
	seg_bus_model u_bus (.clk_i, .start_o(frm_start_i), .byte_valid_o(frm_byte_valid_i),
		.byte_o(frm_byte_i), .end_o(frm_end_i), .edge_o(edge_i));

	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	function integer cat(input [7:0] f);
		case (f)
			8'h08: cat = 3;
			8'h30: cat = 5;
			8'h31: cat = 6;
			8'h32: cat = 7;
			8'h33: cat = 8;
			8'h40: cat = 9;
			8'h50, 8'h51: cat = 10;
			8'h53, 8'h55: cat = 11;
			8'h60: cat = 12;
			8'h61: cat = 13;
			default: cat = 4;
		endcase
	endfunction

	task chk(input [31:0] got, input [31:0] want);
		begin
			n_checks = n_checks + 1;
			if (got !== want)
			begin
				num_errors = num_errors + 1;
				$display("Error at %0t: got %h expected %h", $time, got, want);
			end
		end
	endtask

	task rd(input [4:0] n, input [31:0] want);
		begin
			@(posedge clk_i) rd_req_i <= 1'b1;
			rd_sel_i <= n;
			@(posedge clk_i) rd_req_i <= 1'b0;
			#1 chk({31'h0, rd_valid_o}, 32'h1);
			chk(rd_data_o, want);
		end
	endtask

	task rd_all;
		begin
			for (j = 0; j < 18; j = j + 1)
				rd(j[4:0], cnt[j]);
			rd(5'h13, 32'h0);
			chk(frame_error_o, cnt[1] + cnt[2]);
		end
	endtask

	task zero;
		begin
			for (j = 0; j < 19; j = j + 1)
				cnt[j] = 0;
			prev_pt = 0;
			exp_min = 12'hfff;
			n_dev = 0;
			seen = 256'h0;
		end
	endtask

	task frame(input [7:0] f, input b);
		begin
			u_bus.send(f, b);
			cnt[0] = cnt[0] + 1;
			cnt[1] = cnt[1] + b;
			if (prev_pt && f != 8'h31)
				cnt[2] = cnt[2] + 1;
			prev_pt = (f == 8'h30);
			cnt[cat(f)] = cnt[cat(f)] + 1;
			j = (f >= 8'h30 && f <= 8'h33) ? 14 : (f == 8'h40 || f == 8'h50 || f == 8'h51) ? 15 : (f == 8'h08) ? 17 : 16;
			// frame time runs from the start cycle up to the cycle before the end
			cnt[j] = cnt[j] + 4;
		end
	endtask

	task amp(input [11:0] l, input [7:0] a);
		begin
			@(posedge clk_i) amp_valid_i <= 1'b1;
			amp_level_i <= l;
			amp_addr_i <= a;
			@(posedge clk_i) amp_valid_i <= 1'b0;
			if (l < exp_min)
			begin
				exp_min = l;
				exp_addr = a;
			end
			n_dev = n_dev + !seen[a];
			seen[a] = 1'b1;
		end
	endtask

	// two back-to-back reads of the unused-time counter on an idle bus
	task rd_idle;
		begin
			@(posedge clk_i) rd_req_i <= 1'b1;
			rd_sel_i <= 5'h12;
			@(posedge clk_i) #1 k = rd_data_o;
			@(posedge clk_i) rd_req_i <= 1'b0;
			#1 chk(rd_data_o - k, 32'h00000001);
		end
	endtask

	task wait_sel(input [3:0] s);
		begin
			k = 0;
			while (seg_sel_o !== s && k < 300)
			begin
				@(negedge clk_i);
				k = k + 1;
			end
		end
	endtask

	task test_done;
		begin
			if (num_errors == 0 && n_checks > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask

	initial
	begin
		#100000 num_errors = num_errors + 1;
		test_done;
	end

	initial
	begin
		seed = 32'haf23;
		num_errors = 0;
		n_checks = 0;
		rst_i = 1'b1;
		clear_i = 1'b0;
		rd_req_i = 1'b0;
		rd_sel_i = 5'h00;
		amp_valid_i = 1'b0;
		amp_level_i = 12'h000;
		amp_addr_i = 8'h00;
		seg_enable_i = 16'h0008;
		zero;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1 chk(seg_sel_o, 4'h3);
		chk(seg_active_o, 16'h0008);
		chk(min_level_o, 12'hfff);
		rd_all;
		for (i = 0; i < 26; i = i + 1)
		begin
			k = $random(seed);
			fc = (i == 25) ? 8'h08 : TBL[111-8*((i < 14) ? i : k[7:0] % 14) -: 8];
			bad = (i < 14) ? (i == 2) : k[8];
			frame(fc, bad);
		end
		rd_all;
		chk(jitter_o, 16'h0001);
		for (i = 0; i < 6; i = i + 1)
		begin
			k = $random(seed);
			amp({1'b0, k[10:0]}, {6'h00, k[13:12]});
		end
		repeat (3) @(posedge clk_i);
		#1 chk(min_level_o, exp_min);
		chk(min_level_addr_o, exp_addr);
		chk(device_count_o, n_dev);
		// clear lands on the same edge as the frame end
		fork
			begin
				repeat (45) @(posedge clk_i);
				clear_i <= 1'b1;
				@(posedge clk_i) clear_i <= 1'b0;
			end
			u_bus.send(8'h40, 1'b0);
		join
		zero;
		rd_all;
		chk(device_count_o, 9'h000);
		chk(jitter_o, 16'h0000);
		rd_idle;
		frame(8'h50, 1'b0);
		seg_enable_i <= 16'h0208;
		wait_sel(4'h9);
		chk(seg_sel_o, 4'h9);
		chk(seg_active_o, 16'h0200);
		zero;
		rd_all;
		wait_sel(4'h3);
		chk(seg_sel_o, 4'h3);
		@(posedge clk_i) seg_enable_i <= 16'h0000;
		repeat (2) @(posedge clk_i);
		#1 chk(seg_active_o, 16'h0000);
		test_done;
	end
endmodule
